// *** acs_pkg.sv ***
// Package for the chained output, sync and per-channel check-byte block.
// Assumes a single 20 MHz core clock domain; all pins arrive asynchronous.
package acs_pkg;

  // ==========================================================================
  // Frame layout
  localparam int ACS_CH         = 8;
  localparam int ACS_HDR_BITS   = 8;
  localparam int ACS_DATA_BITS  = 16;
  localparam int ACS_WORD_BITS  = ACS_HDR_BITS + ACS_DATA_BITS;
  localparam int ACS_CNT_W      = 5;

  // ==========================================================================
  // Check-byte constants
  localparam logic [7:0] ACS_CRC_INIT  = 8'hFF;
  localparam logic [4:0] ACS_GRP_SHORT = 5'h04;
  localparam logic [4:0] ACS_GRP_LONG  = 5'h10;

  // ==========================================================================
  // Check-byte selection field values.
  localparam logic [1:0] ACS_CRC_OFF   = 2'h0;
  localparam logic [1:0] ACS_CRC_4     = 2'h1;
  localparam logic [1:0] ACS_CRC_16    = 2'h2;

  // Sync output pulse length in core cycles.
  localparam int         ACS_SYNC_NS    = 50;
  localparam int         ACS_CLK_MHZ    = 20;
  localparam logic [3:0] ACS_SYNC_CYC   =
    4'(((ACS_SYNC_NS * ACS_CLK_MHZ) + 999) / 1000);

  // Output format pin values.
  localparam logic [1:0] ACS_FMT_TWO = 2'h1;

  // Pin group carried from the pins into the core.
  typedef struct packed {
    logic sclk;
    logic chain_a;
    logic chain_b;
    logic frame_rdy;
    logic start_n;
    logic sync_in_n;
  } acs_pins_t;

  // Idle pin levels, used as the synchroniser reset so that no edge is seen after reset.
  localparam acs_pins_t ACS_PINS_IDLE = '{sclk: 1'b0, chain_a: 1'b0, chain_b: 1'b0,
                                          frame_rdy: 1'b1, start_n: 1'b1, sync_in_n: 1'b1};

endpackage : acs_pkg

// *** acs_chain_crc.sv ***
// Chained serial output, sync pulse generation and per-channel check byte.
// Assumes the serial data clock is slow relative to i_clk and sampled here.
//
// Contract
// - Chained output shifts out on rising serial data clock edges.
// - Chain input lanes are sampled on falling serial data clock edges.
// - Two-lane format: lanes zero/one carry upstream chain inputs onward.
// - Lane-zero-only format chains through input a alone, b unused.
// - Async start pulse yields a clock-aligned pulse on sync output.
// - Serial-port sync command also yields an aligned sync pulse.
// - Sync input is sampled on the rising core clock edge.
// - Each channel word is 24 bits: 8-bit header then 16-bit result.
// - Check byte works only in serial-port mode, chosen by select field.
// - Per-channel 8-bit check byte replaces header every 4 or 16 samples.
// - Sync loads every channel check register with all ones.
// - Fourth sample header carries check over all four results incl. its own.
// - After a check header, the register restarts at all ones.
// - Check header appears on all channels together, counted in frames.
// - Slow channels still accumulate and emit, nulled samples included.
// - Generator polynomial is x^8 + x^2 + x + 1.
// - Each frame-ready fall starts a frame unless sync falls in the same cycle: 8 header bits, 16 result bits.
// - While chaining, upper lanes are inputs; lanes zero/one stay outputs.
module acs_chain_crc
  import acs_pkg::*;
#(
  parameter int CH = ACS_CH
) (
  // Clock and reset.
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // Pins from the outside world.
  input  wire logic                     i_serial_data_clock,
  input  wire logic                     i_chain_input_a,
  input  wire logic                     i_chain_input_b,
  input  wire logic                     i_frame_ready_n,
  input  wire logic                     i_start_n,
  input  wire logic                     i_sync_in_n,
  // Configuration.
  input  wire logic [1:0]               i_output_format_pins,
  input  wire logic                     i_spi_mode,
  input  wire logic [1:0]               i_crc_select,
  input  wire logic                     i_spi_sync_cmd,
  // Per-channel results and status headers, stable for a whole frame.
  input  wire logic [CH*16-1:0]         i_result,
  input  wire logic [CH*8-1:0]          i_status,
  input  wire logic [2:0]               i_lane_ch0,
  input  wire logic [2:0]               i_lane_ch1,
  // Outputs.
  output logic                          o_output_lane_zero,
  output logic                          o_output_lane_one,
  output logic                          o_sync_out_n,
  output logic                          o_sync_seen,
  output logic [CH*8-1:0]               o_crc
);
  import acs_pkg::*;

  // ==========================================================================
  // State
  typedef enum logic [1:0] {ACS_IDLE, ACS_HDR, ACS_DATA} acs_phase_t;

  typedef struct packed {
    acs_pins_t               s1;
    acs_pins_t               s2;
    acs_pins_t               s3;
    acs_phase_t              phase;
    logic [4:0]              bitn;
    logic [4:0]              grp;
    logic                    crc_hdr;
    logic [CH*8-1:0]         crc;
    logic [CH*8-1:0]         hdr;
    logic [23:0]             sh0;
    logic [23:0]             sh1;
    logic                    ia;
    logic                    ib;
    logic                    lane0;
    logic                    lane1;
    logic [3:0]              sync_cnt;
    logic                    sync_n;
    logic                    seen;
    logic                    cmd_q;
  } acs_state_t;

  acs_state_t st_q;
  acs_state_t st_d;

  acs_pins_t pins;
  assign pins = '{sclk: i_serial_data_clock, chain_a: i_chain_input_a,
                  chain_b: i_chain_input_b, frame_rdy: i_frame_ready_n,
                  start_n: i_start_n, sync_in_n: i_sync_in_n};

  // Edge terms read from the second and third stage; sync_req also takes i_spi_sync_cmd directly.
  logic sclk_rise;
  logic sclk_fall;
  logic frame_fall;
  logic start_fall;
  logic sync_fall;
  logic sync_req;
  logic crc_on;
  logic [4:0] grp_len;
  wire logic [CH*8-1:0] crc_next;

  assign sclk_rise  = st_q.s2.sclk & ~st_q.s3.sclk;
  assign sclk_fall  = ~st_q.s2.sclk & st_q.s3.sclk;
  assign frame_fall = ~st_q.s2.frame_rdy & st_q.s3.frame_rdy;
  assign start_fall = ~st_q.s2.start_n & st_q.s3.start_n;
  // Either source may request the aligned pulse; the command counts only in serial-port mode.
  assign sync_req   = start_fall || (i_spi_mode && i_spi_sync_cmd && !st_q.cmd_q);
  // Sync input is a core-clock-synchronous level; caught on its falling edge.
  assign sync_fall  = ~st_q.s2.sync_in_n & st_q.s3.sync_in_n;
  // Check byte only exists in serial-port mode with a nonzero select.
  assign crc_on     = i_spi_mode && (i_crc_select != ACS_CRC_OFF);
  assign grp_len    = (i_crc_select == ACS_CRC_16) ? ACS_GRP_LONG
                                                   : ACS_GRP_SHORT;

  // Per-channel check update over one full 16-bit result, MSB first.
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_crc
      // Each channel drives its own slice of a net, so no variable has two writers.
      logic [7:0] crc_g;
      always_comb begin
        logic [7:0] c;
        logic       fb;
        c  = st_q.crc[g*8 +: 8];
        fb = 1'b0;
        for (int k = 15; k >= 0; k--) begin
          fb = i_result[g*16 + k] ^ c[7];
          c  = {c[6:3], c[2] , c[1] ^ fb, c[0] ^ fb, fb};
        end
        crc_g = c;
      end
      assign crc_next[g*8 +: 8] = crc_g;
    end
  endgenerate

  // ==========================================================================
  // Next-state logic
  always_comb begin
    st_d       = st_q;
    st_d.s1    = pins;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    st_d.cmd_q = i_spi_sync_cmd;

    // Aligned sync pulse from async start or a serial-port command.
    if (sync_req) begin
      st_d.sync_cnt = ACS_SYNC_CYC;
    end else if (st_q.sync_cnt != 4'h0) begin
      st_d.sync_cnt = st_q.sync_cnt - 4'h1;
    end
    st_d.sync_n = (st_d.sync_cnt == 4'h0);

    // Sync restarts group counting and presets every check register.
    if (sync_fall) begin
      st_d.crc  = {CH{ACS_CRC_INIT}};
      st_d.grp  = 5'h00;
      st_d.seen = 1'b1;
    end

    // A new frame loads the 24-bit words for both lanes.
    if (frame_fall && !sync_fall) begin
      st_d.phase = ACS_HDR;
      st_d.bitn  = 5'h00;
      // Group count is shared, so every channel emits the check together.
      // Wrapping at or beyond the end means a select change in mid-group cannot
      // let the count run past the long group length.
      st_d.crc_hdr = crc_on && (st_q.grp >= grp_len - 5'h01);
      st_d.grp = (st_q.grp >= grp_len - 5'h01) ? 5'h00 : st_q.grp + 5'h01;
      // Every channel accumulates, nulled results included.
      st_d.hdr = st_q.hdr;
      for (int c = 0; c < CH; c++) begin
        if (st_d.crc_hdr) begin
          st_d.hdr[c*8 +: 8] = crc_next[c*8 +: 8];
          st_d.crc[c*8 +: 8] = ACS_CRC_INIT;
        end else begin
          st_d.hdr[c*8 +: 8] = i_status[c*8 +: 8];
          st_d.crc[c*8 +: 8] = crc_on ? crc_next[c*8 +: 8]
                                      : st_q.crc[c*8 +: 8];
        end
      end
      st_d.sh0 = {st_d.hdr[i_lane_ch0*8 +: 8], i_result[i_lane_ch0*16 +: 16]};
      st_d.sh1 = {st_d.hdr[i_lane_ch1*8 +: 8], i_result[i_lane_ch1*16 +: 16]};
    end else if (sclk_fall) begin
      // Chain inputs captured on the falling edge.
      st_d.ia = st_q.s2.chain_a;
      st_d.ib = (i_output_format_pins == ACS_FMT_TWO) ? st_q.s2.chain_b
                                                      : 1'b0;
      // Shifting on the fall means that after 24 falls only upstream bits remain, first
      // bit on top; shifting on the rise would slip a stale bit in ahead of them.
      st_d.sh0 = {st_q.sh0[22:0], st_d.ia};
      st_d.sh1 = {st_q.sh1[22:0], st_d.ib};
    end else if (sclk_rise) begin
      // Shift-register readback: own word first, then upstream data.
      st_d.lane0 = st_q.sh0[23];
      st_d.lane1 = (i_output_format_pins == ACS_FMT_TWO) ? st_q.sh1[23] : 1'b0;
      if (st_q.phase != ACS_IDLE) begin
        st_d.bitn = st_q.bitn + 5'h01;
        if (st_q.bitn == 5'(ACS_HDR_BITS - 1)) begin
          st_d.phase = ACS_DATA;
        end else if (st_q.bitn == 5'(ACS_WORD_BITS - 1)) begin
          st_d.phase = ACS_IDLE;
        end
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Pin stages start at the pins' idle levels, so no false edge follows reset.
      st_q <= '{phase: ACS_IDLE, sync_n: 1'b1, crc: {CH{ACS_CRC_INIT}},
                s1: ACS_PINS_IDLE, s2: ACS_PINS_IDLE, s3: ACS_PINS_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_output_lane_zero = st_q.lane0;
  assign o_output_lane_one  = st_q.lane1;
  assign o_sync_out_n       = st_q.sync_n;
  assign o_sync_seen        = st_q.seen;
  assign o_crc              = st_q.crc;

  // ==========================================================================
  // Checks
  sequence start_seen_s;
    $fell(st_q.s2.start_n);
  endsequence

  sync_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    start_seen_s |=> !o_sync_out_n) else $error("sync pulse missing after start");

  crc_preset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_fall |=> o_crc == {CH{ACS_CRC_INIT}}) else $error("check not preset");

  lane_shift_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sclk_rise && !frame_fall |=> o_output_lane_zero == $past(st_q.sh0[23]))
    else $error("lane zero not shifted");

  chain_cap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sclk_fall && !frame_fall |=> st_q.ia == $past(st_q.s2.chain_a))
    else $error("chain input not captured");

  crc_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_fall && !sync_fall && crc_on && st_q.grp == grp_len - 5'h01
    |=> st_q.crc_hdr && o_crc == {CH{ACS_CRC_INIT}})
    else $error("check not reloaded");

  crc_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_fall && !crc_on |=> !st_q.crc_hdr) else $error("check header while off");

  grp_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.grp < ACS_GRP_LONG) else $error("group count out of range");

  lane_one_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_output_format_pins != ACS_FMT_TWO && sclk_rise |=> !o_output_lane_one)
    else $error("lane one driven in one-lane format");

  // Sync-side checks: the pulse follows a request, lasts one cycle and loops back.
  sequence sync_arm_s;
    sync_fall;
  endsequence

  sync_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_spi_mode && i_spi_sync_cmd && !st_q.cmd_q |=> !o_sync_out_n)
    else $error("sync pulse missing after command");

  sync_once_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_sync_out_n && !sync_req |=> o_sync_out_n)
    else $error("sync pulse longer than one cycle");

  sync_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_sync_out_n && !sync_req |=> o_sync_out_n)
    else $error("sync pulse without request");

  seen_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_arm_s |=> o_sync_seen)
    else $error("sync not recorded");

  grp_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_arm_s |=> st_q.grp == 5'h00)
    else $error("group count not cleared");

  // Frame-side checks: word load, header choice, accumulation and chain shifting.
  word_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_fall && !sync_fall && !crc_on
    |=> st_q.sh0 == $past({i_status[i_lane_ch0*8 +: 8], i_result[i_lane_ch0*16 +: 16]}))
    else $error("word not loaded with status header");

  crc_hdr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_fall && !sync_fall && crc_on && st_q.grp >= grp_len - 5'h01
    |=> st_q.sh0[23:16] == $past(crc_next[i_lane_ch0*8 +: 8]))
    else $error("check header not substituted");

  crc_accum_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_fall && !sync_fall && crc_on && st_q.grp < grp_len - 5'h01
    |=> o_crc == $past(crc_next))
    else $error("check register did not accumulate");

  chain_shift_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sclk_fall && !frame_fall
    |=> st_q.sh0 == {$past(st_q.sh0[22:0]), $past(st_q.s2.chain_a)})
    else $error("chain bit not shifted in");

  lane_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !sclk_rise |=> $stable(o_output_lane_zero))
    else $error("lane zero moved without a clock rise");

endmodule // acs_chain_crc

// *** acs_host_model.sv ***
// Behavioural far side: upstream chained neighbour, link clock and lane capture.
// Assumes i_go is a one-cycle request taken only while no frame is running.
module acs_host_model (
  // Core clock and frame request.
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [23:0] i_up0,
  input  wire logic [23:0] i_up1,
  // Lanes returned by the block.
  input  wire logic        i_lane0,
  input  wire logic        i_lane1,
  // Link pins and captured lane streams.
  output logic             o_sclk,
  output logic             o_frame_n,
  output logic             o_chain_a,
  output logic             o_chain_b,
  output logic             o_done,
  output logic [47:0]      o_got0,
  output logic [47:0]      o_got1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Frame engine; the link clock stands still between frames.
  initial begin
    {o_sclk, o_chain_a, o_done} = '0;
    {o_frame_n, o_chain_b} = '1;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        #17 o_frame_n = 1'b0;
        #200 o_frame_n = 1'b1;
        #213;
        for (int k = 47; k >= 0; k--) begin
          o_sclk = 1'b1;
          // Upstream bits move after the rise; spent lines toggle so stale data never matches.
          #5 o_chain_a = (k >= 24) ? i_up0[k-24] : ~o_chain_a;
          o_chain_b = (k >= 24) ? i_up1[k-24] : ~o_chain_b;
          #195 o_sclk = 1'b0;
          // Sample late in the low phase, where the lane has long settled.
          #190 o_got0[k] = i_lane0;
          o_got1[k] = i_lane1;
          #10;
        end
        @(posedge i_clk) #1 o_done = 1'b1;
        @(posedge i_clk) #1 o_done = 1'b0;
      end
    end
  end
endmodule // acs_host_model

// *** adc_chain_sync_crc_output_tb.sv ***
// Self-checking bench for the chained output, sync and check-byte block.
// Assumes the host model above drives the link and captures both lanes.
module adc_chain_sync_crc_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic clk, rst, sclk, fr_n, ch_a, ch_b, start_n, spi, cmd, go, done, l0, l1, so_n, seen;
  logic [1:0]   fmt, sel;
  logic [2:0]   c0, c1;
  logic [127:0] res;
  logic [63:0]  sts, crc;
  logic [23:0]  up0, up1;
  logic [47:0]  got0, got1;
  logic [96:0]  e;
  logic [7:0]   cm [8];
  logic [96:0]  q [$];
  int           fcnt, mismatches, n_tests, cyc, seed;

  // ==========================================================================
  // Clock, block and far side.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  acs_chain_crc DUT (.i_clk(clk), .i_rst(rst), .i_serial_data_clock(sclk), .i_chain_input_a(ch_a),
    .i_chain_input_b(ch_b), .i_frame_ready_n(fr_n), .i_start_n(start_n), .i_sync_in_n(so_n),
    .i_output_format_pins(fmt), .i_spi_mode(spi), .i_crc_select(sel), .i_spi_sync_cmd(cmd),
    .i_result(res), .i_status(sts), .i_lane_ch0(c0), .i_lane_ch1(c1), .o_output_lane_zero(l0),
    .o_output_lane_one(l1), .o_sync_out_n(so_n), .o_sync_seen(seen), .o_crc(crc));
  acs_host_model host (.i_clk(clk), .i_go(go), .i_up0(up0), .i_up1(up1), .i_lane0(l0),
    .i_lane1(l1), .o_sclk(sclk), .o_frame_n(fr_n), .o_chain_a(ch_a), .o_chain_b(ch_b),
    .o_done(done), .o_got0(got0), .o_got1(got1));

  // ==========================================================================
  // Comparison, reference check byte and verdict.
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] step(logic [7:0] c, logic [15:0] d);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = d[i] ^ c[7];
      c = {c[6:2], c[1] ^ fb, c[0] ^ fb, fb};
    end
    return c;
  endfunction
  task automatic conclude();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Sync request through the start pin or the serial command; loops back to sync in.
  task automatic do_sync(bit use_cmd, bit exp);
    logic hit;
    hit = 1'b0;
    @(posedge clk) #1;
    if (use_cmd) cmd = 1'b1;
    else start_n = 1'b0;
    repeat (10) begin
      @(posedge clk) #1;
      if (so_n === 1'b0) hit = 1'b1;
    end
    cmd = 1'b0;
    start_n = 1'b1;
    repeat (10) @(posedge clk);
    #1 check("sync pulse", 64'(exp), 64'(hit));
    for (int c = 0; c < 8; c++) cm[c] = ACS_CRC_INIT;
    fcnt = 0;
  endtask

  // One frame with random data; the expected lane streams are queued before it starts.
  task automatic frame(int g);
    logic [7:0] h [8];
    fcnt++;
    sts = {$random(seed), $random(seed)};
    {c0, c1, up0, up1} = 54'({$random(seed), $random(seed)});
    for (int c = 0; c < 8; c++) begin
      res[c*16+:16] = 16'($random(seed));
      cm[c] = step(cm[c], res[c*16+:16]);
      h[c] = sts[c*8+:8];
      if (g != 0 && fcnt % g == 0) begin
        h[c] = cm[c];
        cm[c] = ACS_CRC_INIT;
      end
    end
    q.push_back({fmt == ACS_FMT_TWO, h[c0], res[c0*16+:16], up0, h[c1], res[c1*16+:16], up1});
    go = 1'b1;
    @(posedge clk) #1 go = 1'b0;
    @(posedge done);
    @(posedge clk) #1;
  endtask

  // Scoreboard: the oldest note is taken off as each captured frame appears.
  always @(posedge done) begin
    e = q.pop_front();
    check("lane zero", 64'(e[95:48]), 64'(got0));
    if (e[96]) check("lane one", 64'(e[47:0]), 64'(got1));
    else check("lane one idle", 64'h0, 64'(got1));
  end

  // Hang guard, sized well above the roughly 12000 cycles the sequence needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    seed = 44553;
    {rst, start_n} = 2'b11;
    {spi, cmd, go, c0, c1, res, sts, up0, up1} = '0;
    fmt = ACS_FMT_TWO;
    sel = ACS_CRC_4;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check("crc after reset", {8{ACS_CRC_INIT}}, crc);
    repeat (4) @(posedge clk);
    do_sync(1'b1, 1'b0);
    do_sync(1'b0, 1'b1);
    do_sync(1'b0, 1'b1);
    check("sync seen", 64'h1, 64'(seen));
    check("crc after sync", {8{ACS_CRC_INIT}}, crc);
    spi = 1'b1;
    for (int i = 1; i <= 9; i++) begin
      frame(4);
      if (i == 8) check("crc restart", {8{ACS_CRC_INIT}}, crc);
    end
    do_sync(1'b1, 1'b1);
    fmt = 2'h0;
    sel = ACS_CRC_16;
    repeat (17) frame(16);
    spi = 1'b0;
    fmt = ACS_FMT_TWO;
    sel = ACS_CRC_4;
    do_sync(1'b0, 1'b1);
    repeat (4) frame(0);
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule // adc_chain_sync_crc_output_tb
